// File: pkg/tobc_cfg.svh
// register offsets, field positions, reset values and timing counts of the output logic block
`ifndef TOBC_CFG_SVH
`define TOBC_CFG_SVH

// ==========================================
// register offsets
`define TOBC_OFS_SEL0      8'h1c
`define TOBC_OFS_SRC0      8'h1e
`define TOBC_OFS_SEL1      8'h21
`define TOBC_OFS_SRC1      8'h23
`define TOBC_OFS_NOISE     8'h4e
`define TOBC_OFS_BUCKET    8'h4f
`define TOBC_OFS_SETTLE    8'h50

// ==========================================
// field positions and masks of the combine select and source registers
`define TOBC_BIT_ON        7
`define TOBC_BIT_INV       1
`define TOBC_BIT_AND       0
`define TOBC_SEL_MASK      8'h83
`define TOBC_SRC_MASK      8'h03

// ==========================================
// reset values
`define TOBC_RST_SEL       8'h00
`define TOBC_RST_SRC0      8'h01
`define TOBC_RST_SRC1      8'h02
`define TOBC_RST_NOISE     8'h28
`define TOBC_RST_BUCKET    8'h64
`define TOBC_RST_SETTLE    8'ha0

// ==========================================
// timing: one settle unit in ns, converted to clock cycles at 25 MHz
`define TOBC_SETTLE_UNIT_NS  40
`define TOBC_CLK_PERIOD_NS   40
`define TOBC_SETTLE_UNIT_CYC ((`TOBC_SETTLE_UNIT_NS + `TOBC_CLK_PERIOD_NS - 1) / `TOBC_CLK_PERIOD_NS)

`endif

// File: pkg/tobc_pkg.sv
// types shared by the output logic and baseline tracking block
package tobc_pkg;

	// conversion sequencer states
	typedef enum logic [1:0] {
		TOBC_IDLE,
		TOBC_SETTLE,
		TOBC_DONE
	} tobc_conv_t;

	// one byte of register data
	typedef logic [7:0] tobc_byte_t;

	// raw and baseline count width
	typedef logic [15:0] tobc_count_t;

endpackage

// File: design/tobc_track.sv
// baseline tracker for one sensor: noise gate, bucket and baseline increment
`timescale 1ns/1ps
`include "tobc_cfg.svh"

module tobc_track (
	// clock and reset
	input  wire logic               mclk_i,
	input  wire logic               sys_rst_i,
	// sample input
	input  wire logic               sample_vld_i,
	input  wire tobc_pkg::tobc_count_t raw_i,
	input  wire logic               load_i,
	// shared thresholds
	input  wire tobc_pkg::tobc_byte_t noise_i,
	input  wire tobc_pkg::tobc_byte_t limit_i,
	// state out
	output tobc_pkg::tobc_count_t   base_o,
	output tobc_pkg::tobc_count_t   bucket_o
);
	import tobc_pkg::*;

	tobc_count_t base_r;      // baseline
	tobc_count_t base_nxt;
	tobc_count_t bkt_r;       // accumulator bucket
	tobc_count_t bkt_nxt;
	logic [16:0] diff;        // raw minus baseline, bit 16 set when raw below
	logic [16:0] sum;         // bucket plus difference, bit 16 set on overflow

	// ==========================================
	// next baseline and bucket, once per completed sample
	always_comb begin
		base_nxt = base_r;
		bkt_nxt  = bkt_r;
		diff     = {1'b0, raw_i} - {1'b0, base_r};
		sum      = {1'b0, bkt_r} + diff;
		if (load_i) begin
			// seed baseline from first sample
			base_nxt = raw_i;
			bkt_nxt  = 16'h0000;
		end else if (sample_vld_i && !diff[16] && diff[15:0] != 16'h0000) begin
			if (diff[15:0] > {8'h00, noise_i}) begin
				// above noise: baseline held
				base_nxt = base_r;
			end else if (diff[15:0] < {8'h00, noise_i}) begin
				// inside noise band: accumulate
				if (sum[16] || sum[15:0] >= {8'h00, limit_i}) begin
					base_nxt = base_r + 16'h0001;
					bkt_nxt  = 16'h0000;
				end else begin
					bkt_nxt = sum[15:0];
				end
			end
		end
	end

	// register stage
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			base_r <= 16'h0000;
			bkt_r  <= 16'h0000;
		end else begin
			base_r <= base_nxt;
			bkt_r  <= bkt_nxt;
		end
	end

	assign base_o   = base_r;
	assign bucket_o = bkt_r;

	// ==========================================
	// checks
	a_noise_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		sample_vld_i && !load_i && raw_i > base_r && (raw_i - base_r) > {8'h00, noise_i}
		|=> base_r == $past(base_r))
		else $error("baseline moved above noise threshold");
	a_bucket_fill: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		base_r == $past(base_r) + 16'h0001 && !$past(load_i) |-> bkt_r == 16'h0000)
		else $error("bucket not cleared on baseline step");
	a_no_drop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!sample_vld_i && !load_i |=> base_r == $past(base_r) && bkt_r == $past(bkt_r))
		else $error("tracking changed without sample");
	c_base_step: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
		sample_vld_i ##1 base_r == $past(base_r) + 16'h0001);

endmodule

// File: design/tobc_regs.sv
// register bank for output combining logic and shared baseline tracking parameters
`timescale 1ns/1ps
`include "tobc_cfg.svh"

module tobc_regs #(
	parameter bit TWO_BUTTON = 1'b1
) (
	// clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  sys_rst_i,
	// register port from the serial slave
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	input  wire tobc_pkg::tobc_byte_t  reg_addr_i,
	input  wire tobc_pkg::tobc_byte_t  reg_wdata_i,
	output tobc_pkg::tobc_byte_t       reg_rdata_o,
	// device mode and output enables
	input  wire logic                  setup_mode_i,
	input  wire logic [1:0]            out_enable_i,
	// sensors
	input  wire logic [1:0]            sensor_status_i,
	input  wire logic [1:0]            sensor_on_i,
	input  wire logic                  conv_start_i,
	input  wire tobc_pkg::tobc_count_t raw0_i,
	input  wire tobc_pkg::tobc_count_t raw1_i,
	// results
	output logic                       output_pin_zero_o,
	output logic                       output_pin_one_o,
	output logic [1:0]                 combine_active_o,
	output logic                       settling_o,
	output logic                       sample_done_o,
	output tobc_pkg::tobc_count_t      base0_o,
	output tobc_pkg::tobc_count_t      base1_o
);
	import tobc_pkg::*;

	// ==========================================
	// register storage
	tobc_byte_t sel0_r, sel0_nxt;    // combine select, output zero
	tobc_byte_t sel1_r, sel1_nxt;    // combine select, output one
	tobc_byte_t src0_r, src0_nxt;    // combine source, output zero
	tobc_byte_t src1_r, src1_nxt;    // combine source, output one
	tobc_byte_t noise_r, noise_nxt;  // noise_level_value
	tobc_byte_t limit_r, limit_nxt;  // bucket_limit_value
	tobc_byte_t settle_r, settle_nxt; // settle_delay_value
	tobc_byte_t rdata_r, rdata_nxt;  // read data register

	// write decode
	always_comb begin
		sel0_nxt   = sel0_r;
		sel1_nxt   = sel1_r;
		src0_nxt   = src0_r;
		src1_nxt   = src1_r;
		noise_nxt  = noise_r;
		limit_nxt  = limit_r;
		settle_nxt = settle_r;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`TOBC_OFS_SEL0: begin
					// output zero enabled only
					if (out_enable_i[0])
						sel0_nxt = reg_wdata_i & `TOBC_SEL_MASK;
				end
				`TOBC_OFS_SEL1: begin
					if (TWO_BUTTON && out_enable_i[1])
						sel1_nxt = reg_wdata_i & `TOBC_SEL_MASK;
				end
				`TOBC_OFS_SRC0: src0_nxt = reg_wdata_i & `TOBC_SRC_MASK;
				`TOBC_OFS_SRC1: begin
					if (TWO_BUTTON)
						src1_nxt = reg_wdata_i & `TOBC_SRC_MASK;
				end
				`TOBC_OFS_NOISE:  noise_nxt = reg_wdata_i;
				`TOBC_OFS_BUCKET: limit_nxt = reg_wdata_i;
				`TOBC_OFS_SETTLE: begin
					// setup mode only
					if (setup_mode_i)
						settle_nxt = reg_wdata_i;
				end
				default: ;
			endcase
		end
	end

	// read mux; unmapped and absent registers read zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`TOBC_OFS_SEL0:   rdata_nxt = sel0_r;
				`TOBC_OFS_SEL1:   rdata_nxt = TWO_BUTTON ? sel1_r : 8'h00;
				`TOBC_OFS_SRC0:   rdata_nxt = src0_r;
				`TOBC_OFS_SRC1:   rdata_nxt = TWO_BUTTON ? src1_r : 8'h00;
				`TOBC_OFS_NOISE:  rdata_nxt = noise_r;
				`TOBC_OFS_BUCKET: rdata_nxt = limit_r;
				`TOBC_OFS_SETTLE: rdata_nxt = settle_r;
				default:          rdata_nxt = 8'h00;
			endcase
		end
	end

	// register stage
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sel0_r   <= `TOBC_RST_SEL;
			sel1_r   <= `TOBC_RST_SEL;
			src0_r   <= `TOBC_RST_SRC0;
			src1_r   <= TWO_BUTTON ? `TOBC_RST_SRC1 : 8'h00;
			noise_r  <= `TOBC_RST_NOISE;
			limit_r  <= `TOBC_RST_BUCKET;
			settle_r <= `TOBC_RST_SETTLE;
			rdata_r  <= 8'h00;
		end else begin
			sel0_r   <= sel0_nxt;
			sel1_r   <= sel1_nxt;
			src0_r   <= src0_nxt;
			src1_r   <= src1_nxt;
			noise_r  <= noise_nxt;
			limit_r  <= limit_nxt;
			settle_r <= settle_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;

	// ==========================================
	// combining logic for the two outputs
	logic [1:0] pick0, pick1;  // selected sensor statuses
	logic       res0, res1;    // combined results
	logic       pin0_r, pin0_nxt;
	logic       pin1_r, pin1_nxt;

	// combine: OR or AND of selected statuses, optional inversion
	always_comb begin
		pick0 = src0_r[1:0] & sensor_status_i;
		pick1 = src1_r[1:0] & sensor_status_i;
		// AND over selected only; empty selection gives 0
		res0 = sel0_r[`TOBC_BIT_AND] ? (pick0 == src0_r[1:0] && |src0_r[1:0]) : |pick0;
		res1 = sel1_r[`TOBC_BIT_AND] ? (pick1 == src1_r[1:0] && |src1_r[1:0]) : |pick1;
		pin0_nxt = 1'b0;
		pin1_nxt = 1'b0;
		if (sel0_r[`TOBC_BIT_ON] && out_enable_i[0])
			pin0_nxt = res0 ^ sel0_r[`TOBC_BIT_INV];
		if (TWO_BUTTON && sel1_r[`TOBC_BIT_ON] && out_enable_i[1])
			pin1_nxt = res1 ^ sel1_r[`TOBC_BIT_INV];
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pin0_r <= 1'b0;
			pin1_r <= 1'b0;
		end else begin
			pin0_r <= pin0_nxt;
			pin1_r <= pin1_nxt;
		end
	end

	assign output_pin_zero_o   = pin0_r;
	assign output_pin_one_o    = pin1_r;
	assign combine_active_o[0] = sel0_r[`TOBC_BIT_ON];
	assign combine_active_o[1] = sel1_r[`TOBC_BIT_ON];

	// ==========================================
	// conversion settle sequencer, shared by all sensors
	tobc_conv_t  st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt;   // settle cycles left
	logic [15:0] settle_cyc;       // settle length in cycles
	logic        first_r, first_nxt; // baseline seeding pending

	assign settle_cyc = 16'(settle_r) * 16'(`TOBC_SETTLE_UNIT_CYC);

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		first_nxt = first_r;
		case (st_r)
			TOBC_IDLE: begin
				if (conv_start_i) begin
					st_nxt  = TOBC_SETTLE;
					cnt_nxt = settle_cyc;
				end
			end
			TOBC_SETTLE: begin
				// timed delay before sampling
				if (cnt_r <= 16'h0001)
					st_nxt = TOBC_DONE;
				else
					cnt_nxt = cnt_r - 16'h0001;
			end
			TOBC_DONE: begin
				st_nxt    = TOBC_IDLE;
				first_nxt = 1'b0;
			end
			default: st_nxt = TOBC_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			st_r    <= TOBC_IDLE;
			cnt_r   <= 16'h0000;
			first_r <= 1'b1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			first_r <= first_nxt;
		end
	end

	assign settling_o    = (st_r == TOBC_SETTLE);
	assign sample_done_o = (st_r == TOBC_DONE);

	// ==========================================
	// per-sensor baseline trackers
	logic [1:0] trk_vld;
	assign trk_vld = {2{st_r == TOBC_DONE}} & sensor_on_i;

	tobc_track u_trk0 (
		.mclk_i       (mclk_i),
		.sys_rst_i    (sys_rst_i),
		.sample_vld_i (trk_vld[0]),
		.raw_i        (raw0_i),
		.load_i       (trk_vld[0] & first_r),
		.noise_i      (noise_r),
		.limit_i      (limit_r),
		.base_o       (base0_o),
		.bucket_o     ()
	);

	tobc_track u_trk1 (
		.mclk_i       (mclk_i),
		.sys_rst_i    (sys_rst_i),
		.sample_vld_i (trk_vld[1] & TWO_BUTTON),
		.raw_i        (raw1_i),
		.load_i       (trk_vld[1] & first_r & TWO_BUTTON),
		.noise_i      (noise_r),
		.limit_i      (limit_r),
		.base_o       (base1_o),
		.bucket_o     ()
	);

	// ==========================================
	// checks
	a_sel_locked: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `TOBC_OFS_SEL0 && !out_enable_i[0] |=> $stable(sel0_r))
		else $error("select written while output disabled");
	a_settle_lock: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `TOBC_OFS_SETTLE && !setup_mode_i |=> $stable(settle_r))
		else $error("settle written outside setup");
	a_pin_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!sel0_r[`TOBC_BIT_ON] |=> !output_pin_zero_o)
		else $error("output zero driven with combining off");
	a_pin_or: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		sel0_r[7] && out_enable_i[0] && !sel0_r[0]
		|=> output_pin_zero_o == ($past(|(src0_r[1:0] & sensor_status_i)) ^ $past(sel0_r[1])))
		else $error("output zero OR result wrong");
	a_pin_and: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		sel0_r[7] && out_enable_i[0] && sel0_r[0] && src0_r[1:0] == 2'b11
		|=> output_pin_zero_o == ((&$past(sensor_status_i)) ^ $past(sel0_r[1])))
		else $error("output zero AND result wrong");
	// one-button build: second output and its registers stay absent
	a_pin_one: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!TWO_BUTTON |-> !output_pin_one_o && !combine_active_o[1])
		else $error("second output driven on one-button part");
	a_one_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!TWO_BUTTON && reg_rd_i &&
		(reg_addr_i == `TOBC_OFS_SEL1 || reg_addr_i == `TOBC_OFS_SRC1) |=> reg_rdata_o == 8'h00)
		else $error("absent register read nonzero");
	a_sel1_locked: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `TOBC_OFS_SEL1 && !out_enable_i[1] |=> $stable(sel1_r))
		else $error("second select written while output disabled");
	a_pin_gate1: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!sel1_r[`TOBC_BIT_ON] || !out_enable_i[1] |=> !output_pin_one_o)
		else $error("output one driven while off or disabled");
	a_sel_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `TOBC_OFS_SEL0 && out_enable_i[0]
		|=> sel0_r == ($past(reg_wdata_i) & `TOBC_SEL_MASK))
		else $error("select write did not land");
	a_settle_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		st_r == TOBC_IDLE && conv_start_i && settle_r == 8'h02 |=> settling_o [*2] ##1 sample_done_o)
		else $error("settle phase length wrong");
	a_done_pulse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		sample_done_o |=> !sample_done_o)
		else $error("sample done held too long");
	c_and_on: cover property (@(posedge mclk_i) sel0_r[0] && output_pin_zero_o);
	c_inv_on: cover property (@(posedge mclk_i) sel1_r[1] && output_pin_one_o);
	c_settle: cover property (@(posedge mclk_i) settling_o ##1 sample_done_o);

endmodule

// File: verif/tobc_host.sv
// register host model that drives the byte-wide register port of the block
`timescale 1ns/1ps

module tobc_host (
	// clock
	input  wire logic                 mclk_i,
	// register port
	output logic                      reg_wr_o,
	output logic                      reg_rd_o,
	output tobc_pkg::tobc_byte_t      reg_addr_o,
	output tobc_pkg::tobc_byte_t      reg_wdata_o,
	input  wire tobc_pkg::tobc_byte_t reg_rdata_i
);
	import tobc_pkg::*;
	// ==========================================
	// idle bus from time zero
	initial begin
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// ==========================================
	// one write; callers keep the noise limit in range and settle before thresholds
	task automatic wr(input tobc_byte_t a, input tobc_byte_t d);
		@(negedge mclk_i);
		reg_wr_o    = 1'b1;
		reg_addr_o  = a;
		reg_wdata_o = d;
		@(negedge mclk_i);
		reg_wr_o    = 1'b0;
		// released lines show no stale value
		reg_addr_o  = ~a;
		reg_wdata_o = ~d;
	endtask
	// one read: data is registered on the edge that samples the strobe, taken one cycle after the strobe drops
	task automatic rd(input tobc_byte_t a, output tobc_byte_t d);
		@(negedge mclk_i);
		reg_rd_o   = 1'b1;
		reg_addr_o = a;
		@(negedge mclk_i);
		reg_rd_o   = 1'b0;
		reg_addr_o = ~a;
		@(negedge mclk_i);
		d = reg_rdata_i;
	endtask
endmodule

// File: verif/tobc_regs_tb.sv
// self-checking testbench of the output logic and baseline tracking registers
`timescale 1ns/1ps

module tobc_regs_tb;
	import tobc_pkg::*;
	// ==========================================
	// stimulus and observed signals
	typedef struct {logic [7:0] sel; logic [7:0] src; logic [1:0] st; logic pin;} tobc_row_t;
	logic        mclk_i, sys_rst_i, reg_wr, reg_rd, setup_mode, conv_start;
	logic [1:0]  out_enable, sensor_status, sensor_on, active;
	tobc_byte_t  reg_addr, reg_wdata, rdata, rdata_one, d;
	tobc_count_t raw0, raw1, base0, base1;
	logic        pin0, pin1, settling, sample_done;
	int          err_count, checks_done, cycles, n;
	tobc_row_t   rows [9];

	`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
		$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end

	// ==========================================
	// design, two-button build and one-button build on one bus
	tobc_regs #(.TWO_BUTTON(1'b1)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_rdata_o(rdata), .setup_mode_i(setup_mode), .out_enable_i(out_enable),
		.sensor_status_i(sensor_status), .sensor_on_i(sensor_on), .conv_start_i(conv_start),
		.raw0_i(raw0), .raw1_i(raw1), .output_pin_zero_o(pin0), .output_pin_one_o(pin1),
		.combine_active_o(active), .settling_o(settling), .sample_done_o(sample_done),
		.base0_o(base0), .base1_o(base1));
	tobc_regs #(.TWO_BUTTON(1'b0)) dut_one_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_rdata_o(rdata_one), .setup_mode_i(setup_mode), .out_enable_i(out_enable),
		.sensor_status_i(sensor_status), .sensor_on_i(sensor_on), .conv_start_i(conv_start),
		.raw0_i(raw0), .raw1_i(raw1), .output_pin_zero_o(), .output_pin_one_o(),
		.combine_active_o(), .settling_o(), .sample_done_o(), .base0_o(), .base1_o());
	tobc_host host_u (.mclk_i(mclk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(rdata));

	// ==========================================
	// 25 MHz clock and hang limit
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			give_verdict();
		end
	end

	// ==========================================
	// closing report
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one conversion; n counts cycles with settling high
	task automatic sample(input tobc_count_t r);
		int k;
		n    = 0;
		raw0 = r;
		raw1 = r + 16'h0100;
		@(negedge mclk_i);
		conv_start = 1'b1;
		@(negedge mclk_i);
		conv_start = 1'b0;
		for (k = 0; k < 300 && sample_done !== 1'b1; k++) begin
			if (settling === 1'b1)
				n++;
			@(negedge mclk_i);
		end
		repeat (2) @(negedge mclk_i);
	endtask

	// ==========================================
	// main sequence
	initial begin
		// combine rows: select, source, status, expected pin
		rows = '{'{8'h80, 8'h03, 2'b01, 1'b1}, '{8'h81, 8'h03, 2'b01, 1'b0},
			'{8'h81, 8'h03, 2'b11, 1'b1}, '{8'h83, 8'h03, 2'b11, 1'b0},
			'{8'h82, 8'h01, 2'b00, 1'b1}, '{8'h00, 8'h03, 2'b11, 1'b0},
			'{8'h80, 8'h02, 2'b01, 1'b0}, '{8'h81, 8'h00, 2'b11, 1'b0},
			'{8'h80, 8'h02, 2'b10, 1'b1}};
		{err_count, checks_done, cycles} = '0;
		{setup_mode, conv_start, sensor_status} = '0;
		out_enable = 2'b10;
		sensor_on  = 2'b11;
		raw0       = 16'h0000;
		raw1       = 16'h0000;
		sys_rst_i  = 1'b1;
		repeat (3) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		// reset values, unmapped offset reads zero
		host_u.rd(8'h1c, d); `CHK(d, 8'h00)
		host_u.rd(8'h1e, d); `CHK(d, 8'h01)
		host_u.rd(8'h21, d); `CHK(d, 8'h00)
		host_u.rd(8'h23, d); `CHK(d, 8'h02)
		host_u.rd(8'h4e, d); `CHK(d, 8'h28)
		host_u.rd(8'h4f, d); `CHK(d, 8'h64)
		host_u.rd(8'h50, d); `CHK(d, 8'ha0)
		host_u.rd(8'h30, d); `CHK(d, 8'h00)
		// write to select of a disabled output is dropped
		host_u.wr(8'h1c, 8'h80);
		host_u.rd(8'h1c, d); `CHK(d, 8'h00)
		host_u.wr(8'h21, 8'h80);
		host_u.rd(8'h21, d); `CHK(d, 8'h80)
		`CHK(rdata_one, 8'h00)
		host_u.wr(8'h23, 8'h01);
		host_u.rd(8'h23, d); `CHK(rdata_one, 8'h00)
		`CHK(d, 8'h01)
		out_enable = 2'b11;
		// table of combine cases on both outputs
		foreach (rows[i]) begin
			host_u.wr(8'h1c, rows[i].sel);
			host_u.wr(8'h1e, rows[i].src);
			host_u.wr(8'h21, rows[i].sel);
			host_u.wr(8'h23, rows[i].src);
			sensor_status = rows[i].st;
			repeat (3) @(negedge mclk_i);
			`CHK(pin0, rows[i].pin)
			`CHK(pin1, rows[i].pin)
			`CHK(active, {rows[i].sel[7], rows[i].sel[7]})
		end
		// each select governs only its own output
		host_u.wr(8'h1c, 8'h82);
		host_u.wr(8'h21, 8'h80);
		repeat (3) @(negedge mclk_i);
		`CHK({pin1, pin0}, 2'b10)
		// bits outside the fields read back zero
		host_u.wr(8'h1c, 8'hff);
		host_u.rd(8'h1c, d); `CHK(d, 8'h83)
		host_u.wr(8'h1e, 8'hff);
		host_u.rd(8'h1e, d); `CHK(d, 8'h03)
		// second select locked while its output is disabled
		out_enable = 2'b01;
		host_u.wr(8'h21, 8'h00);
		host_u.rd(8'h21, d); `CHK(d, 8'h80)
		`CHK(pin1, 1'b0)
		out_enable = 2'b11;
		// settle register writable only in setup mode
		host_u.wr(8'h50, 8'h05);
		host_u.rd(8'h50, d); `CHK(d, 8'ha0)
		setup_mode = 1'b1;
		host_u.wr(8'h50, 8'h02);
		host_u.rd(8'h50, d); `CHK(d, 8'h02)
		host_u.wr(8'h4e, 8'h0a);
		host_u.wr(8'h4f, 8'h05);
		// first sample seeds the baseline
		sample(16'h03e8);
		`CHK(n, 2)
		`CHK(base0, 16'h03e8)
		`CHK(base1, 16'h04e8)
		// difference above the noise limit holds
		sample(16'h03fc);
		`CHK(base0, 16'h03e8)
		`CHK(base1, 16'h04e8)
		// small differences fill the bucket, then step the baseline
		sample(16'h03eb);
		`CHK(base0, 16'h03e8)
		`CHK(base1, 16'h04e8)
		sample(16'h03eb);
		`CHK(base0, 16'h03e9)
		`CHK(base1, 16'h04e9)
		// reset in mid-run returns registers, pins and trackers to reset state
		sys_rst_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		`CHK({base1, base0}, 32'h00000000)
		`CHK({pin1, pin0}, 2'b00)
		host_u.rd(8'h50, d); `CHK(d, 8'ha0)
		host_u.rd(8'h1c, d); `CHK(d, 8'h00)
		give_verdict();
	end
endmodule
